// file: verilog/rrl_defs.svh
// Constants for the return and rotate-left execution block
`ifndef RRL_DEFS_SVH
`define RRL_DEFS_SVH
`define RRL_DW        8
`define RRL_PCW       13
`define RRL_AW        8
`define RRL_STK_DEPTH 8
`define RRL_SPW       3
`define RRL_MSB       7
`define RRL_SP_ONE    3'h1
`define RRL_ACC_RST   8'h00
`define RRL_PC_RST    13'h0000
`define RRL_INT_VEC   13'h0004
`define RRL_SP_RST    3'h0
`endif

// file: verilog/rrl_pkg.sv
// Types for the return and rotate-left execution block
`include "rrl_defs.svh"
package rrl_pkg;
   typedef logic [`RRL_DW-1:0]  rrl_byte_t;
   typedef logic [`RRL_PCW-1:0] rrl_pc_t;
   typedef logic [`RRL_AW-1:0]  rrl_addr_t;
   typedef enum logic [2:0] {
      RRL_OP_NONE  = 3'h0,
      RRL_OP_RET   = 3'h1,
      RRL_OP_RETX  = 3'h2,
      RRL_OP_INTERRUPT_RETURN  = 3'h3,
      RRL_OP_RL    = 3'h4,
      RRL_OP_RLA   = 3'h5,
      RRL_OP_RLC   = 3'h6,
      RRL_OP_CALL  = 3'h7
   } rrl_op_e;
   typedef enum logic [1:0] {
      RRL_ST_IDLE  = 2'h0,
      RRL_ST_WRITE = 2'h1
   } rrl_state_e;
endpackage

// file: verilog/rrl_rot_if.sv
// Interface carrying operand and rotate results between modules
`include "rrl_defs.svh"
interface rrl_rot_if;
   logic [`RRL_DW-1:0] operand;   // Byte read from data memory
   logic               carry_in;  // Current carry flag
   logic [`RRL_DW-1:0] circ;      // Circular left result
   logic [`RRL_DW-1:0] thru;      // Through-carry left result
   logic               carry_out; // Carry after through-carry rotate
   modport core (output operand, output carry_in, input circ, input thru, input carry_out);
   modport unit (input operand, input carry_in, output circ, output thru, output carry_out);
endinterface

// file: verilog/rrl_rotator.sv
// Combinational left rotator, circular and through carry
`include "rrl_defs.svh"
module rrl_rotator (
   rrl_rot_if.unit rot   // Operand in, rotated results out
);
   // Circular: bit 7 wraps into bit 0
   assign rot.circ      = {rot.operand[`RRL_MSB-1:0], rot.operand[`RRL_MSB]};
   // Nine-bit rotate: old carry into bit 0, old bit 7 out to carry
   assign rot.thru      = {rot.operand[`RRL_MSB-1:0], rot.carry_in};
   assign rot.carry_out = rot.operand[`RRL_MSB];
endmodule // rrl_rotator

// file: verilog/rrl_exec.sv
// Execution of returns and left rotates for an 8-bit core
`include "rrl_defs.svh"
module rrl_exec (
   input  wire logic              mclk,          // 50 MHz clock
   input  wire logic              rst_n,         // Async reset, active low
   input  wire logic              op_valid,      // One-cycle instruction strobe
   input  rrl_pkg::rrl_op_e       op_code,       // Instruction to execute
   input  rrl_pkg::rrl_byte_t     op_imm,        // Immediate operand
   input  rrl_pkg::rrl_addr_t     op_addr,       // Data memory address
   input  rrl_pkg::rrl_pc_t       op_pc,         // Return address for call
   input  rrl_pkg::rrl_byte_t     mem_rdata,     // Data memory read byte
   input  wire logic              int_pending,   // Interrupt request level
   output rrl_pkg::rrl_pc_t       pc,            // Program counter
   output rrl_pkg::rrl_byte_t     acc,           // Accumulator
   output logic                   carry,         // Carry flag
   output logic                   zero,          // Zero flag, held
   output logic                   master_interrupt_enable, // Global enable
   output logic                   mem_we,        // Write strobe
   output rrl_pkg::rrl_addr_t     mem_waddr,     // Write address
   output rrl_pkg::rrl_byte_t     mem_wdata,     // Write data
   output logic                   int_taken,     // Interrupt entry pulse
   output logic                   busy           // Write-back in progress
);
   import rrl_pkg::*;

   rrl_rot_if rot ();
   rrl_rotator u_rot (.rot(rot));

   rrl_pc_t    stack_r [`RRL_STK_DEPTH];
   logic [`RRL_SPW-1:0] sp_r;
   rrl_pc_t    pc_r;
   rrl_byte_t  acc_r;
   logic       carry_r, zero_r, mie_r;
   logic       we_r, itk_r;
   rrl_addr_t  waddr_r;
   rrl_byte_t  wdata_r;
   rrl_state_e st_r;

   // Operand routing
   assign rot.operand  = mem_rdata;
   assign rot.carry_in = carry_r;

   // Instruction decode
   wire go       = op_valid && (st_r == RRL_ST_IDLE);
   wire is_ret   = go && (op_code == RRL_OP_RET || op_code == RRL_OP_RETX || op_code == RRL_OP_INTERRUPT_RETURN);
   wire is_call  = go && (op_code == RRL_OP_CALL);
   wire is_rl    = go && (op_code == RRL_OP_RL);
   wire is_rla   = go && (op_code == RRL_OP_RLA);
   wire is_rlc   = go && (op_code == RRL_OP_RLC);
   wire is_interrupt_return  = go && (op_code == RRL_OP_INTERRUPT_RETURN);
   wire [`RRL_SPW-1:0] sp_dec = sp_r - `RRL_SP_ONE;
   wire rrl_pc_t ret_pc = stack_r[sp_dec];
   // A pending request is honoured once enabled, no write-back is open and no instruction is taken
   wire int_go   = int_pending && (mie_r || is_interrupt_return) && !go && (st_r == RRL_ST_IDLE);
   wire int_now  = int_pending && is_interrupt_return;

   // Next program counter; an interrupt at interrupt return vectors away first
   wire rrl_pc_t pc_nxt = int_now ? `RRL_INT_VEC :
                          is_ret  ? ret_pc      :
                          int_go  ? `RRL_INT_VEC : pc_r;
   // Stack push of the return address on interrupt entry
   wire push_int = int_go || int_now;

   // Return stack storage and pointer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sp_r <= `RRL_SP_RST;
      end else if (is_call || (push_int && !is_ret)) begin
         sp_r <= sp_r + `RRL_SP_ONE;
      end else if (is_ret && !int_now) begin
         sp_r <= sp_dec;
      end
   end

   // Storage holds no control state, so it needs no reset
   always_ff @(posedge mclk) begin
      if (is_call) begin
         stack_r[sp_r] <= op_pc;
      end else if (int_now) begin
         stack_r[sp_dec] <= ret_pc;
      end else if (int_go) begin
         stack_r[sp_r] <= pc_r;
      end
   end

   // Program counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) pc_r <= `RRL_PC_RST;
      else        pc_r <= pc_nxt;
   end

   // Accumulator: immediate on RRL_OP_RETX only, rotated byte on rotate-to-acc
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= `RRL_ACC_RST;
      end else if (go && op_code == RRL_OP_RETX) begin
         acc_r <= op_imm;
      end else if (is_rla) begin
         acc_r <= rot.circ;
      end
   end

   // Flags: only the through-carry rotate touches carry; zero is held
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         carry_r <= 1'b0;
         zero_r  <= 1'b0;
      end else if (is_rlc) begin
         carry_r <= rot.carry_out;
      end
   end

   // Master enable: set by interrupt return, cleared on interrupt entry
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)        mie_r <= 1'b0;
      else if (push_int) mie_r <= 1'b0;
      else if (is_interrupt_return)  mie_r <= 1'b1;
   end

   // Interrupt entry pulse
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) itk_r <= 1'b0;
      else        itk_r <= push_int;
   end

   // Write-back path; rotates in place are written one cycle later
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         we_r    <= 1'b0;
         waddr_r <= '0;
         wdata_r <= '0;
         st_r    <= RRL_ST_IDLE;
      end else begin
         we_r <= is_rl || is_rlc;
         st_r <= (is_rl || is_rlc) ? RRL_ST_WRITE : RRL_ST_IDLE;
         if (is_rl) begin
            waddr_r <= op_addr;
            wdata_r <= rot.circ;
         end else if (is_rlc) begin
            waddr_r <= op_addr;
            wdata_r <= rot.thru;
         end
      end
   end

   assign pc        = pc_r;
   assign acc       = acc_r;
   assign carry     = carry_r;
   assign zero      = zero_r;
   assign master_interrupt_enable = mie_r;
   assign mem_we    = we_r;
   assign mem_waddr = waddr_r;
   assign mem_wdata = wdata_r;
   assign int_taken = itk_r;
   // Write strobe flop doubles as busy, so the pin comes straight from a register
   assign busy      = we_r;
endmodule // rrl_exec

// file: test/rrl_exec_chk.sv
// Checker for the return and rotate-left execution block
`include "rrl_defs.svh"
module rrl_exec_chk (
   input wire logic          mclk,        // Clock
   input wire logic          rst_n,       // Reset, active low
   input wire logic          op_valid,    // Strobe
   input rrl_pkg::rrl_op_e   op_code,     // Opcode
   input rrl_pkg::rrl_byte_t op_imm,      // Immediate
   input rrl_pkg::rrl_addr_t op_addr,     // Address
   input rrl_pkg::rrl_byte_t mem_rdata,   // Read byte
   input wire logic          int_pending, // Request
   input rrl_pkg::rrl_pc_t   pc,          // Program counter
   input rrl_pkg::rrl_byte_t acc,         // Accumulator
   input wire logic          carry,       // Carry
   input wire logic          zero,        // Zero
   input wire logic          master_interrupt_enable, // Enable
   input wire logic          mem_we,      // Write strobe
   input rrl_pkg::rrl_addr_t mem_waddr,   // Write address
   input rrl_pkg::rrl_byte_t mem_wdata,   // Write data
   input wire logic          int_taken,   // Entry pulse
   input wire logic          busy         // Write-back
);
   timeunit 1ns;
   timeprecision 1ps;
   import rrl_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Requests ignored while busy must not count
   wire tk = op_valid && !busy;
   // Write-back lasts exactly one cycle, then the core is free
   sequence s_wb;
      mem_we && busy && mem_waddr == $past(op_addr) ##1 !mem_we && !busy;
   endsequence
   property p_ret;
      tk && op_code == RRL_OP_RET |=> $stable(acc) && $stable(carry) && $stable(zero);
   endproperty
   property p_retx;
      tk && op_code == RRL_OP_RETX |=> acc == $past(op_imm) && $stable(carry);
   endproperty
   property p_interrupt_return;
      tk && op_code == RRL_OP_INTERRUPT_RETURN && !int_pending |=> master_interrupt_enable && !int_taken;
   endproperty
   property p_pend;
      tk && op_code == RRL_OP_INTERRUPT_RETURN && int_pending |=> pc == `RRL_INT_VEC && int_taken;
   endproperty
   property p_rl;
      tk && op_code == RRL_OP_RL |=> s_wb and (mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])});
   endproperty
   property p_rla;
      tk && op_code == RRL_OP_RLA |=> acc == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && !mem_we;
   endproperty
   property p_rlc;
      tk && op_code == RRL_OP_RLC |=> s_wb and (mem_wdata == {$past(mem_rdata[6:0]), $past(carry)});
   endproperty
   property p_zero;
      tk && op_code == RRL_OP_RLC |=> carry == $past(mem_rdata[7]) && $stable(zero) && $stable(acc);
   endproperty
   a_ret: assert property (p_ret) else $error("return changed a flag");
   a_retx: assert property (p_retx) else $error("immediate not loaded");
   a_interrupt_return: assert property (p_interrupt_return) else $error("enable not set");
   a_pend: assert property (p_pend) else $error("pending entry missed");
   a_rl: assert property (p_rl) else $error("rotate write wrong");
   a_rla: assert property (p_rla) else $error("rotate to acc wrong");
   a_rlc: assert property (p_rlc) else $error("carry rotate write wrong");
   a_zero: assert property (p_zero) else $error("carry rotate flags wrong");
endmodule // rrl_exec_chk
bind rrl_exec rrl_exec_chk rrl_exec_chk_inst (.mclk, .rst_n, .op_valid, .op_code, .op_imm, .op_addr, .mem_rdata,
   .int_pending, .pc, .acc, .carry, .zero, .master_interrupt_enable, .mem_we, .mem_waddr, .mem_wdata, .int_taken, .busy);

// file: test/tb_top.sv
// Self-checking testbench for the return and rotate-left execution block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rrl_pkg::*;
   logic      mclk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, int_pending = 1'b0;
   rrl_op_e   op_code = RRL_OP_NONE;
   rrl_byte_t op_imm = 8'h00, mem_rdata = 8'h00, acc, mem_wdata;
   rrl_addr_t op_addr = 8'h00, mem_waddr;
   rrl_pc_t   op_pc = 13'h0000, pc;
   logic      carry, zero, master_interrupt_enable, mem_we, int_taken, busy;
   int        failures = 0, comparisons = 0, cycles = 0;
   rrl_exec rrl_exec_inst (.mclk, .rst_n, .op_valid, .op_code, .op_imm, .op_addr, .op_pc, .mem_rdata, .int_pending,
      .pc, .acc, .carry, .zero, .master_interrupt_enable, .mem_we, .mem_waddr, .mem_wdata, .int_taken, .busy);
   initial forever #10 mclk = ~mclk;
   // Hang guard, far above the 46 or so cycles needed
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input rrl_pc_t seen, input rrl_pc_t exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // One-cycle strobe; returns just after the taking edge
   task automatic issue(input rrl_op_e c, input rrl_pc_t v, input rrl_byte_t d, input logic ip);
      @(posedge mclk);
      #1 op_valid = 1'b1;
      op_code     = c;
      op_pc       = v;
      op_imm      = v[7:0];
      op_addr     = v[7:0];
      mem_rdata   = d;
      int_pending = ip;
      @(posedge mclk);
      #1 {op_valid, int_pending} = 2'b00;
   endtask
   task automatic t_returns;
      issue(RRL_OP_CALL, 13'h1abc, 8'h00, 1'b0);
      issue(RRL_OP_CALL, 13'h0123, 8'h00, 1'b0);
      issue(RRL_OP_RET, 13'h0000, 8'h00, 1'b0);
      chk("pc", pc, 13'h0123);
      issue(RRL_OP_RETX, 13'h00a5, 8'h00, 1'b0);
      chk("pc", pc, 13'h1abc);
      chk("acc", 13'(acc), 13'h00a5);
      $display("Test returns done");
   endtask
   task automatic t_interrupt_return;
      issue(RRL_OP_CALL, 13'h0456, 8'h00, 1'b0);
      issue(RRL_OP_INTERRUPT_RETURN, 13'h0000, 8'h00, 1'b0);
      chk("pc", pc, 13'h0456);
      chk("mie", 13'(master_interrupt_enable), 13'h0001);
      issue(RRL_OP_CALL, 13'h0789, 8'h00, 1'b0);
      issue(RRL_OP_INTERRUPT_RETURN, 13'h0000, 8'h00, 1'b1);
      chk("pc", pc, 13'h0004);
      chk("taken", 13'(int_taken), 13'h0001);
      issue(RRL_OP_RET, 13'h0000, 8'h00, 1'b0);
      chk("pc", pc, 13'h0789);
      $display("Test interrupt return done");
   endtask
   // Request while idle and enabled: entry pushes the current pc
   task automatic t_entry;
      issue(RRL_OP_CALL, 13'h0321, 8'h00, 1'b0);
      issue(RRL_OP_INTERRUPT_RETURN, 13'h0000, 8'h00, 1'b0);
      @(posedge mclk);
      #1 int_pending = 1'b1;
      @(posedge mclk);
      #1 int_pending = 1'b0;
      chk("pc", pc, 13'h0004);
      chk("taken", 13'({int_taken, master_interrupt_enable}), 13'h0002);
      issue(RRL_OP_RET, 13'h0000, 8'h00, 1'b0);
      chk("pc", pc, 13'h0321);
      $display("Test interrupt entry done");
   endtask
   // Carry is tracked here, never read back as a reference
   task automatic t_rotate;
      rrl_byte_t d [3] = '{8'h81, 8'hc3, 8'h4e};
      logic ec = 1'b0;
      foreach (d[i]) begin
         issue(RRL_OP_RL, 13'h0030 + 13'(i), d[i], 1'b0);
         chk("wdata", 13'(mem_wdata), 13'({d[i][6:0], d[i][7]}));
         chk("busy", 13'({mem_we, busy, carry}), 13'({2'b11, ec}));
         issue(RRL_OP_RLA, 13'h0040, d[i], 1'b0);
         chk("acc", 13'({mem_we, carry, acc}), 13'({1'b0, ec, d[i][6:0], d[i][7]}));
         issue(RRL_OP_RLC, 13'h0050, d[i], 1'b0);
         chk("wdata", 13'(mem_wdata), 13'({d[i][6:0], ec}));
         ec = d[i][7];
         chk("flags", 13'({mem_we, carry, zero}), 13'({1'b1, ec, 1'b0}));
      end
      $display("Test rotates done");
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      #1 rst_n = 1'b1;
      t_returns();
      t_interrupt_return();
      t_entry();
      t_rotate();
      finish_test();
   end
endmodule // tb_top
